/* File: rtl/tlic_ctrl.sv */
// two-level interrupt controller with wishbone register access
//
// Summary of operation
// - twelve request sources, each assigned high or low priority.
// - primary enable bit 7 is global gate for all maskable sources.
// - primary enable bits 6,5,4 enable converter, timer 2, uart.
// - primary enable bits 3..0 enable timer 1, pin 1, timer 0, pin 0.
// - primary priority bits 6,5,4 set converter, timer 2, uart level.
// - primary priority bits 3..0 set timer1, pin1, timer0, pin0; bit7 reserved.
// - secondary bits 6,5,4 set interval counter, supply monitor, serial level.
// - secondary bits 2,1,0 enable interval counter, supply monitor, serial.
// - secondary register resets to a0h.
// - high preempts low; same level never preempts; high served first.
// - equal-level requests resolved by fixed polling order.
// - accepted request supplies its own vector address to the core.
// - watchdog is always high and ignores the global gate.
`timescale 1ns/1ps

module tlic_ctrl
    import tlic_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // wishbone slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [9:0]        adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    // source events, one-cycle pulses
    input  wire logic [NSRC-1:0]   src_event_i,
    // processor core
    output logic                   irq_req_o,
    output logic      [VEC_W-1:0]  irq_vector_o,
    output logic                   irq_level_o,
    input  wire logic              irq_accept_i,
    input  wire logic              irq_return_i
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [REG_W-1:0] pen_q,  pen_d;
    logic [REG_W-1:0] sec_q,  sec_d;
    logic [REG_W-1:0] pri_q,  pri_d;
    logic [NSRC-1:0]  pend_q, pend_d;
    tlic_svc_t        svc_q,  svc_d;
    logic             req_q,  req_d;
    logic             lvl_q,  lvl_d;
    logic [SEL_W-1:0] sel_q,  sel_d;
    logic [VEC_W-1:0] vec_q,  vec_d;
    logic             ack_q,  ack_d;
    logic [31:0]      rdat_q, rdat_d;

    logic [NSRC-1:0]  en_vec;
    logic [NSRC-1:0]  hi_vec;
    logic [NSRC-1:0]  live;
    logic [NSRC-1:0]  live_hi;
    logic [NSRC-1:0]  live_lo;
    logic             any_hi;
    logic             any_lo;
    logic [SEL_W-1:0] win_hi;
    logic [SEL_W-1:0] win_lo;
    logic             gate;
    logic [IDX_W-1:0] idx;
    logic             wr_now;
    logic             accept;

    // ------------------------------------------------------------
    // vector lookup
    // ------------------------------------------------------------
    function automatic logic [VEC_W-1:0] vec_of(input logic [SEL_W-1:0] s);
        logic [VEC_W-1:0] v;
        v = VEC_PIN0;
        unique case (int'(s))
            S_SUPPLY:   v = VEC_SUPPLY;
            S_WATCHDOG: v = VEC_WATCHDOG;
            S_PIN0:     v = VEC_PIN0;
            S_CONV:     v = VEC_CONV;
            S_TIMER0:   v = VEC_TIMER0;
            S_PIN1:     v = VEC_PIN1;
            S_TIMER1:   v = VEC_TIMER1;
            S_SERIF:    v = VEC_SERIF;
            S_UART_RX:  v = VEC_UART;
            S_UART_TX:  v = VEC_UART;
            S_TIMER2:   v = VEC_TIMER2;
            S_INTERVAL: v = VEC_INTERVAL;
            default:    v = VEC_PIN0;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // per-source enable and level
    // ------------------------------------------------------------
    always_comb
    begin
        en_vec = '0;
        hi_vec = '0;
        en_vec[S_CONV]     = pen_q[B_CONVERTER];
        en_vec[S_TIMER2]   = pen_q[B_TIMER2];
        en_vec[S_UART_RX]  = pen_q[B_UART];
        en_vec[S_UART_TX]  = pen_q[B_UART];
        en_vec[S_TIMER1]   = pen_q[B_TIMER1];
        en_vec[S_PIN1]     = pen_q[B_PIN1];
        en_vec[S_TIMER0]   = pen_q[B_TIMER0];
        en_vec[S_PIN0]     = pen_q[B_PIN0];
        en_vec[S_INTERVAL] = sec_q[B2_TIC_EN];
        en_vec[S_SUPPLY]   = sec_q[B2_PSM_EN];
        en_vec[S_SERIF]    = sec_q[B2_SER_EN];
        // the watchdog only raises an event when configured for it
        en_vec[S_WATCHDOG] = 1'b1;
        hi_vec[S_CONV]     = pri_q[B_CONVERTER];
        hi_vec[S_TIMER2]   = pri_q[B_TIMER2];
        hi_vec[S_UART_RX]  = pri_q[B_UART];
        hi_vec[S_UART_TX]  = pri_q[B_UART];
        hi_vec[S_TIMER1]   = pri_q[B_TIMER1];
        hi_vec[S_PIN1]     = pri_q[B_PIN1];
        hi_vec[S_TIMER0]   = pri_q[B_TIMER0];
        hi_vec[S_PIN0]     = pri_q[B_PIN0];
        hi_vec[S_INTERVAL] = sec_q[B2_TIC_PRIO];
        hi_vec[S_SUPPLY]   = sec_q[B2_PSM_PRIO];
        hi_vec[S_SERIF]    = sec_q[B2_SER_PRIO];
        hi_vec[S_WATCHDOG] = 1'b1;
    end

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    assign gate = pen_q[B_GLOBAL_EN];

    always_comb
    begin
        live = pend_q & en_vec & {NSRC{gate}};
        live[S_WATCHDOG] = pend_q[S_WATCHDOG];
        live_hi = live & hi_vec;
        live_lo = live & ~hi_vec;
        any_hi  = |live_hi;
        any_lo  = |live_lo;
        win_hi  = '0;
        win_lo  = '0;
        // downward scan so the lowest index, polled first, wins
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (live_hi[i])
            begin
                win_hi = SEL_W'(i);
            end
            if (live_lo[i])
            begin
                win_lo = SEL_W'(i);
            end
        end
    end

    assign accept = req_q & irq_accept_i;

    // offer is re-evaluated every cycle so a later high request replaces a low one
    always_comb
    begin
        req_d = 1'b0;
        lvl_d = 1'b0;
        sel_d = '0;
        unique case (svc_q)
            SVC_NONE:
            begin
                if (any_hi)
                begin
                    req_d = 1'b1;
                    lvl_d = 1'b1;
                    sel_d = win_hi;
                end
                else if (any_lo)
                begin
                    req_d = 1'b1;
                    sel_d = win_lo;
                end
            end
            SVC_LOW:
            begin
                // a low routine is only broken into by a high request
                req_d = any_hi;
                lvl_d = any_hi;
                sel_d = win_hi;
            end
            SVC_HIGH, SVC_BOTH:
            begin
                req_d = 1'b0;
            end
        endcase
        // withdraw for one cycle after an accept so the same source is not offered twice
        if (accept)
        begin
            req_d = 1'b0;
        end
        vec_d = vec_of(sel_d);
    end

    // ------------------------------------------------------------
    // service level tracking
    // ------------------------------------------------------------
    always_comb
    begin
        svc_d = svc_q;
        if (accept)
        begin
            unique case (svc_q)
                SVC_NONE: svc_d = lvl_q ? SVC_HIGH : SVC_LOW;
                SVC_LOW:  svc_d = SVC_BOTH;
                SVC_HIGH: svc_d = SVC_HIGH;
                SVC_BOTH: svc_d = SVC_BOTH;
            endcase
        end
        else if (irq_return_i)
        begin
            unique case (svc_q)
                SVC_NONE: svc_d = SVC_NONE;
                SVC_LOW:  svc_d = SVC_NONE;
                SVC_HIGH: svc_d = SVC_NONE;
                SVC_BOTH: svc_d = SVC_LOW;
            endcase
        end
    end

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    assign idx    = adr_i[9:2];
    assign ack_d  = cyc_i & stb_i & ~ack_q;
    // writes land on the edge that samples ack
    assign wr_now = cyc_i & stb_i & we_i & ack_q & sel_i[0];

    always_comb
    begin
        pen_d  = pen_q;
        sec_d  = sec_q;
        pri_d  = pri_q;
        rdat_d = '0;
        if (wr_now)
        begin
            unique case (idx)
                IDX_PRIMARY_ENABLE:   pen_d = dat_i[REG_W-1:0];
                // reserved bits are dropped on write; secondary bit 7 still reads one from its a0h reset value until written
                IDX_SECONDARY:        sec_d = dat_i[REG_W-1:0] & MASK_SECONDARY;
                IDX_PRIMARY_PRIORITY: pri_d = dat_i[REG_W-1:0] & MASK_PRIMARY_PRIO;
                default:              pen_d = pen_q;
            endcase
        end
        if (ack_d)
        begin
            unique case (idx)
                IDX_PRIMARY_ENABLE:   rdat_d[REG_W-1:0] = pen_q;
                IDX_SECONDARY:        rdat_d[REG_W-1:0] = sec_q;
                IDX_PRIMARY_PRIORITY: rdat_d[REG_W-1:0] = pri_q;
                IDX_PENDING_LO:       rdat_d[REG_W-1:0] = pend_q[REG_W-1:0];
                IDX_PENDING_HI:       rdat_d[NSRC-REG_W-1:0] = pend_q[NSRC-1:REG_W];
                IDX_SERVICE_STATUS:   rdat_d[3:0] = svc_q;
                default:              rdat_d = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pending flags
    // ------------------------------------------------------------
    always_comb
    begin
        pend_d = pend_q;
        // acceptance clears the served flag
        if (accept)
        begin
            pend_d[sel_q] = 1'b0;
        end
        // software clears by writing ones
        if (cyc_i & stb_i & we_i & ack_q)
        begin
            if (idx == IDX_PENDING_LO && sel_i[0])
            begin
                pend_d[REG_W-1:0] = pend_d[REG_W-1:0] & ~dat_i[REG_W-1:0];
            end
            if (idx == IDX_PENDING_HI && sel_i[0])
            begin
                pend_d[NSRC-1:REG_W] = pend_d[NSRC-1:REG_W] & ~dat_i[NSRC-REG_W-1:0];
            end
        end
        // an event in the clearing cycle is kept
        pend_d = pend_d | src_event_i;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pen_q  <= RST_PRIMARY_ENABLE;
            sec_q  <= RST_SECONDARY;
            pri_q  <= RST_PRIMARY_PRIORITY;
            pend_q <= RST_PENDING;
            svc_q  <= SVC_NONE;
            req_q  <= 1'b0;
            lvl_q  <= 1'b0;
            sel_q  <= '0;
            vec_q  <= '0;
            ack_q  <= 1'b0;
            rdat_q <= '0;
        end
        else
        begin
            pen_q  <= pen_d;
            sec_q  <= sec_d;
            pri_q  <= pri_d;
            pend_q <= pend_d;
            svc_q  <= svc_d;
            req_q  <= req_d;
            lvl_q  <= lvl_d;
            sel_q  <= sel_d;
            vec_q  <= vec_d;
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign ack_o        = ack_q;
    assign dat_o        = rdat_q;
    assign irq_req_o    = req_q;
    assign irq_level_o  = lvl_q;
    assign irq_vector_o = vec_q;

endmodule

/* File: shared/tlic_pkg.sv */
// constants shared by the two-level interrupt controller
package tlic_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NSRC      = 12;
    localparam int SEL_W     = 4;
    localparam int VEC_W     = 16;
    localparam int REG_W     = 8;
    localparam int IDX_W     = 8;

    // ------------------------------------------------------------
    // register indices (byte address = 4 x index)
    // ------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_PRIMARY_ENABLE   = 8'ha8;
    localparam logic [IDX_W-1:0] IDX_SECONDARY        = 8'ha9;
    localparam logic [IDX_W-1:0] IDX_PRIMARY_PRIORITY = 8'hb8;
    localparam logic [IDX_W-1:0] IDX_PENDING_LO       = 8'hc0;
    localparam logic [IDX_W-1:0] IDX_PENDING_HI       = 8'hc1;
    localparam logic [IDX_W-1:0] IDX_SERVICE_STATUS   = 8'hc2;

    // ------------------------------------------------------------
    // reset values and write masks
    // ------------------------------------------------------------
    localparam logic [REG_W-1:0] RST_PRIMARY_ENABLE   = 8'h00;
    localparam logic [REG_W-1:0] RST_SECONDARY        = 8'ha0;
    localparam logic [REG_W-1:0] RST_PRIMARY_PRIORITY = 8'h00;
    localparam logic [REG_W-1:0] MASK_SECONDARY       = 8'h77;
    localparam logic [REG_W-1:0] MASK_PRIMARY_PRIO    = 8'h7f;
    localparam logic [NSRC-1:0]  RST_PENDING          = 12'h000;

    // ------------------------------------------------------------
    // bit positions
    // ------------------------------------------------------------
    localparam int B_GLOBAL_EN   = 7;
    localparam int B_CONVERTER   = 6;
    localparam int B_TIMER2      = 5;
    localparam int B_UART        = 4;
    localparam int B_TIMER1      = 3;
    localparam int B_PIN1        = 2;
    localparam int B_TIMER0      = 1;
    localparam int B_PIN0        = 0;
    localparam int B2_TIC_PRIO   = 6;
    localparam int B2_PSM_PRIO   = 5;
    localparam int B2_SER_PRIO   = 4;
    localparam int B2_TIC_EN     = 2;
    localparam int B2_PSM_EN     = 1;
    localparam int B2_SER_EN     = 0;

    // ------------------------------------------------------------
    // source index = polling position, 0 polled first
    // ------------------------------------------------------------
    localparam int S_SUPPLY   = 0;
    localparam int S_WATCHDOG = 1;
    localparam int S_PIN0     = 2;
    localparam int S_CONV     = 3;
    localparam int S_TIMER0   = 4;
    localparam int S_PIN1     = 5;
    localparam int S_TIMER1   = 6;
    localparam int S_SERIF    = 7;
    localparam int S_UART_RX  = 8;
    localparam int S_UART_TX  = 9;
    localparam int S_TIMER2   = 10;
    localparam int S_INTERVAL = 11;

    // ------------------------------------------------------------
    // vector addresses
    // ------------------------------------------------------------
    localparam logic [VEC_W-1:0] VEC_PIN0     = 16'h0003;
    localparam logic [VEC_W-1:0] VEC_TIMER0   = 16'h000b;
    localparam logic [VEC_W-1:0] VEC_PIN1     = 16'h0013;
    localparam logic [VEC_W-1:0] VEC_TIMER1   = 16'h001b;
    localparam logic [VEC_W-1:0] VEC_UART     = 16'h0023;
    localparam logic [VEC_W-1:0] VEC_TIMER2   = 16'h002b;
    localparam logic [VEC_W-1:0] VEC_CONV     = 16'h0033;
    localparam logic [VEC_W-1:0] VEC_SERIF    = 16'h003b;
    localparam logic [VEC_W-1:0] VEC_SUPPLY   = 16'h0043;
    localparam logic [VEC_W-1:0] VEC_INTERVAL = 16'h0053;
    localparam logic [VEC_W-1:0] VEC_WATCHDOG = 16'h005b;

    // ------------------------------------------------------------
    // service level state, one-hot
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SVC_NONE = 4'b0001,
        SVC_LOW  = 4'b0010,
        SVC_HIGH = 4'b0100,
        SVC_BOTH = 4'b1000
    } tlic_svc_t;

endpackage

/* File: testbench/tlic_ctrl_properties.sv */
// assertion checker for the two-level interrupt controller
`timescale 1ns/1ps

module tlic_ctrl_props
    import tlic_pkg::*;
(
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic             cyc_i,
    input wire logic             stb_i,
    input wire logic             we_i,
    input wire logic [9:0]       adr_i,
    input wire logic [3:0]       sel_i,
    input wire logic [31:0]      dat_i,
    input wire logic [31:0]      dat_o,
    input wire logic             ack_o,
    input wire logic [NSRC-1:0]  src_event_i,
    input wire logic             irq_req_o,
    input wire logic [VEC_W-1:0] irq_vector_o,
    input wire logic             irq_level_o,
    input wire logic             irq_accept_i,
    input wire logic             irq_return_i
);
    // svc bit1: a high routine runs, bit0: a low routine runs
    logic [7:0] ie_q, ie_d;
    logic [1:0] svc_q, svc_d;
    logic       wr_ie;

    assign wr_ie = cyc_i && stb_i && we_i && ack_o && sel_i[0]
                   && adr_i[9:2] == IDX_PRIMARY_ENABLE;

    always_comb
    begin
        ie_d  = wr_ie ? dat_i[7:0] : ie_q;
        svc_d = svc_q;
        if (irq_req_o && irq_accept_i)
            svc_d = irq_level_o ? (svc_q | 2'b10) : 2'b01;
        else if (irq_return_i)
            svc_d = svc_q[1] ? (svc_q & 2'b01) : 2'b00;
    end

    always_ff @(posedge clk_i)
    begin
        ie_q  <= rst_i ? 8'h00 : ie_d;
        svc_q <= rst_i ? 2'b00 : svc_d;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus request not answered next cycle");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_IDLE: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    AST_PRIO_RSVD: assert property (ack_o && !we_i
        && adr_i[9:2] == IDX_PRIMARY_PRIORITY |-> !dat_o[7])
        else $error("reserved priority bit reads one");
    AST_REQ_DROP: assert property (irq_req_o && irq_accept_i |=> !irq_req_o)
        else $error("request stays after acceptance");
    AST_GATE: assert property (!ie_q[B_GLOBAL_EN] && !$past(ie_q[B_GLOBAL_EN])
        && irq_req_o |-> irq_vector_o == VEC_WATCHDOG)
        else $error("maskable request with global gate off");
    AST_OWN_EN: assert property (!ie_q[B_PIN0] && !$past(ie_q[B_PIN0])
        && irq_req_o |-> irq_vector_o != VEC_PIN0)
        else $error("disabled source requested");
    AST_WDOG_LVL: assert property (irq_req_o && irq_vector_o == VEC_WATCHDOG
        |-> irq_level_o)
        else $error("watchdog offered at low level");
    AST_NO_SAME: assert property (irq_req_o && svc_q != 2'b00
        |-> irq_level_o && !svc_q[1])
        else $error("request preempts routine of same or higher level");
    AST_WDOG_LAT: assert property (src_event_i[S_WATCHDOG] && !svc_q[1] && !irq_accept_i
        ##1 !irq_accept_i |=> irq_req_o && irq_level_o)
        else $error("watchdog request missing two cycles after event");

    cover property (irq_req_o && irq_accept_i && irq_level_o && svc_q == 2'b01);
    cover property (irq_req_o && irq_accept_i && !irq_level_o);
    cover property (ack_o && we_i);
endmodule

bind tlic_ctrl tlic_ctrl_props tlic_ctrl_props_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .src_event_i, .irq_req_o, .irq_vector_o,
    .irq_level_o, .irq_accept_i, .irq_return_i);

/* File: testbench/tlic_core_model.sv */
// core-side partner: accepts offered requests and returns from routines
`timescale 1ns/1ps

module tlic_core_model
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       irq_req_i,
    input  wire logic       take_i,
    input  wire logic       ret_i,
    output logic            accept_o,
    output logic            return_o,
    output logic [7:0]      n_acc_o
);
    logic       acc_q, acc_d, ret_q, ret_d;
    logic [7:0] n_q, n_d;

    // take_i lets the bench answer promptly or hold an offer waiting
    always_comb
    begin
        acc_d = take_i && irq_req_i && !acc_q;
        ret_d = ret_i;
        n_d   = n_q + {7'h0, acc_d};
    end

    always_ff @(posedge clk_i)
    begin
        acc_q <= rst_i ? 1'b0 : acc_d;
        ret_q <= rst_i ? 1'b0 : ret_d;
        n_q   <= rst_i ? 8'h00 : n_d;
    end

    assign accept_o = acc_q;
    assign return_o = ret_q;
    assign n_acc_o  = n_q;
endmodule

/* File: testbench/tb.sv */
// self-checking bench for the two-level interrupt controller
`timescale 1ns/1ps

module tb;
    import tlic_pkg::*;
    logic            clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic            take = 0, ret_c = 0, acc, rtn, req, lvl, ack_o;
    logic [9:0]      adr_i = '0;
    logic [3:0]      sel_i = '0;
    logic [31:0]     dat_i = '0, dat_o;
    logic [NSRC-1:0] ev = '0;
    logic [15:0]     vec;
    logic [7:0]      n_acc;
    int              n_errors = 0, total_checks = 0;
    logic [15:0]     vt [NSRC] = '{VEC_SUPPLY, VEC_WATCHDOG, VEC_PIN0, VEC_CONV,
        VEC_TIMER0, VEC_PIN1, VEC_TIMER1, VEC_SERIF, VEC_UART, VEC_UART,
        VEC_TIMER2, VEC_INTERVAL};

    tlic_ctrl tlic_ctrl_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .src_event_i(ev), .irq_req_o(req), .irq_vector_o(vec),
        .irq_level_o(lvl), .irq_accept_i(acc), .irq_return_i(rtn));
    tlic_core_model tlic_core_model_i (.clk_i, .rst_i, .irq_req_i(req), .take_i(take),
        .ret_i(ret_c), .accept_o(acc), .return_o(rtn), .n_acc_o(n_acc));

    initial
    forever #25 clk_i = ~clk_i;

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic stuck(input string m);
        n_errors++;
        $display("Error %0t: %s timed out", $time, m);
        report_and_stop();
    endtask

    // one classic cycle; entered just after a rising edge, ack judged where it is settled
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [31:0] rdata);
        int k;
        cyc_i <= 1;
        stb_i <= 1;
        we_i  <= w;
        adr_i <= {idx, 2'b00};
        sel_i <= 4'h1;
        dat_i <= {24'h0, wd};
        k = 0;
        do
        begin
            @(negedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        if (ack_o !== 1'b1)
            stuck("bus");
        rdata = dat_o;
        // the request stands through the edge that samples ack high
        @(posedge clk_i);
        cyc_i <= 0;
        stb_i <= 0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        wb(1'b1, idx, d, r);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] e);
        logic [31:0] r;
        wb(1'b0, idx, 8'h00, r);
        chk(r, e);
    endtask

    task automatic pulse(input logic [NSRC-1:0] m);
        ev <= m;
        @(posedge clk_i);
        ev <= '0;
    endtask

    // wait for an offer, compare it, then let the core take it
    task automatic offer(input logic [15:0] v, input logic l);
        int         k;
        logic [7:0] n0;
        n0 = n_acc;
        k = 0;
        do
        begin
            @(negedge clk_i);
            k++;
        end while (req !== 1'b1 && k < 20);
        if (req !== 1'b1)
            stuck("offer");
        chk({16'h0, vec}, {16'h0, v});
        chk({31'h0, lvl}, {31'h0, l});
        @(posedge clk_i);
        take <= 1;
        k = 0;
        do
        begin
            @(negedge clk_i);
            k++;
        end while (n_acc === n0 && k < 20);
        if (n_acc === n0)
            stuck("accept");
        @(posedge clk_i);
        take <= 0;
    endtask

    // return has no answer on the link, so a few cycles let it land
    task automatic ret();
        ret_c <= 1;
        @(posedge clk_i);
        ret_c <= 0;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic no_req(input int n);
        repeat (n)
        begin
            @(negedge clk_i);
            chk({31'h0, req}, 32'h0);
        end
        // hand back just after a rising edge like every other task
        @(posedge clk_i);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd(IDX_PRIMARY_ENABLE, 32'h0);
        rd(IDX_SECONDARY, 32'ha0);
        rd(IDX_PRIMARY_PRIORITY, 32'h0);
        rd(8'h10, 32'h0);
        wr(IDX_PRIMARY_ENABLE, 8'hff);
        rd(IDX_PRIMARY_ENABLE, 32'hff);
        wr(IDX_PRIMARY_PRIORITY, 8'hff);
        rd(IDX_PRIMARY_PRIORITY, 32'h7f);
        wr(IDX_SECONDARY, 8'h77);
        rd(IDX_SECONDARY, 32'h77);
        wr(8'h10, 8'h55);
        rd(IDX_PRIMARY_ENABLE, 32'hff);
        $display("test regs done");
    endtask

    task automatic t_vec();
        for (int p = 0; p < 2; p++)
        begin
            wr(IDX_PRIMARY_PRIORITY, p ? 8'h7f : 8'h00);
            wr(IDX_SECONDARY, p ? 8'h77 : 8'h07);
            for (int s = 0; s < NSRC; s++)
            begin
                pulse(12'h1 << s);
                offer(vt[s], p == 1 || s == S_WATCHDOG);
                ret();
            end
        end
        $display("test vectors done");
    endtask

    task automatic t_poll();
        wr(IDX_PRIMARY_PRIORITY, 8'h00);
        wr(IDX_SECONDARY, 8'h07);
        pulse(12'hfff);
        offer(VEC_WATCHDOG, 1'b1);
        ret();
        for (int s = 0; s < NSRC; s++)
        begin
            if (s != S_WATCHDOG)
            begin
                offer(vt[s], 1'b0);
                ret();
            end
        end
        $display("test polling done");
    endtask

    task automatic t_gate();
        wr(IDX_PRIMARY_ENABLE, 8'h7f);
        pulse(12'h1 << S_PIN0 | 12'h1 << S_TIMER1 | 12'h1 << S_WATCHDOG);
        offer(VEC_WATCHDOG, 1'b1);
        ret();
        no_req(6);
        rd(IDX_PENDING_LO, (32'h1 << S_PIN0) | (32'h1 << S_TIMER1));
        wr(IDX_PRIMARY_ENABLE, 8'hff);
        offer(VEC_PIN0, 1'b0);
        ret();
        offer(VEC_TIMER1, 1'b0);
        ret();
        wr(IDX_PRIMARY_ENABLE, 8'h80);
        pulse(12'h1 << S_TIMER0);
        no_req(6);
        rd(IDX_PENDING_LO, 32'h1 << S_TIMER0);
        wr(IDX_PENDING_LO, 8'h1 << S_TIMER0);
        rd(IDX_PENDING_LO, 32'h0);
        pulse(12'h1 << S_TIMER0);
        wr(IDX_PRIMARY_ENABLE, 8'h82);
        offer(VEC_TIMER0, 1'b0);
        ret();
        $display("test gating done");
    endtask

    task automatic t_preempt();
        wr(IDX_PRIMARY_ENABLE, 8'hff);
        wr(IDX_PRIMARY_PRIORITY, 8'h02);
        pulse(12'h1 << S_PIN0 | 12'h1 << S_TIMER0);
        offer(VEC_TIMER0, 1'b1);
        ret();
        offer(VEC_PIN0, 1'b0);
        rd(IDX_SERVICE_STATUS, {28'h0, SVC_LOW});
        pulse(12'h1 << S_PIN1);
        no_req(6);
        pulse(12'h1 << S_TIMER0);
        offer(VEC_TIMER0, 1'b1);
        rd(IDX_SERVICE_STATUS, {28'h0, SVC_BOTH});
        ret();
        no_req(4);
        ret();
        offer(VEC_PIN1, 1'b0);
        ret();
        $display("test preemption done");
    endtask

    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        no_req(2);
        t_regs();
        t_vec();
        t_poll();
        t_gate();
        t_preempt();
        report_and_stop();
    end
endmodule
